// [verilog/dds_port_pkg.sv]
package dds_port_pkg;

    // Serial instruction byte fields
    localparam int INSTR_READ_BIT = 7;
    localparam int INSTR_ADDR_MSB = 3;

    // Serial port timing
    localparam int BITS_PER_BYTE = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Control word location and reset value
    localparam logic [3:0] CTRL_ADDR = 4'h7;
    localparam logic [5:0] CTRL_BASE = 6'h1D;
    localparam logic [1:0] CTRL_TOP_LANE = 2'h3;
    localparam logic [31:0] CTRL_RESET = 32'h1064_0120;

    // Control word bit positions
    localparam int B_COMP_PD = 28;
    localparam int B_HALT = 27;
    localparam int B_CDAC_PD = 26;
    localparam int B_DAC_PD = 25;
    localparam int B_DIG_PD = 24;
    localparam int B_VCO_GAIN = 22;
    localparam int B_PLL_BYP = 21;
    localparam int B_MULT_MSB = 20;
    localparam int B_MULT_LSB = 16;
    localparam int B_CLR_ACC1 = 15;
    localparam int B_CLR_ALL = 14;
    localparam int B_TRIANGLE = 13;
    localparam int B_MODE_MSB = 11;
    localparam int B_MODE_LSB = 9;
    localparam int B_INT_UPD = 8;
    localparam int B_SINC_BYP = 6;
    localparam int B_KEY_EN = 5;
    localparam int B_KEY_INT = 4;
    localparam int B_LSB_FIRST = 1;
    localparam int B_OUT_ACTIVE = 0;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h0,
        MODE_FSK = 3'h1,
        MODE_RAMP_FSK = 3'h2,
        MODE_CHIRP = 3'h3,
        MODE_BPSK = 3'h4
    } op_mode_t;

    // Byte base of each serial address; unmapped ones share the last byte of address 11
    localparam logic [15:0][5:0] REG_BASE = {
        6'h27, 6'h27, 6'h27, 6'h27, 6'h26, 6'h25, 6'h23, 6'h21,
        6'h1D, 6'h1A, 6'h16, 6'h10, 6'h0A, 6'h04, 6'h02, 6'h00};

    // Data bytes of each serial address
    localparam logic [15:0][2:0] REG_BYTES = {
        3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2,
        3'h4, 3'h3, 3'h4, 3'h6, 3'h6, 3'h6, 3'h2, 3'h2};

    // Register bank depth in bytes
    localparam int BANK_BYTES = 40;

    function automatic logic [5:0] reg_base(input logic [3:0] a);
        return REG_BASE[a];
    endfunction

    function automatic logic [2:0] reg_bytes(input logic [3:0] a);
        return REG_BYTES[a];
    endfunction

endpackage

// [verilog/reg_bank_mem.sv]
`timescale 1ns/1ns

// Buffered register bytes, one shared port, registered read data
module reg_bank_mem
    import dds_port_pkg::*;
#(
    parameter int DW = 8,
    parameter int AW = 6,
    parameter int DEPTH = BANK_BYTES
)
(
    // Clock
    input  wire logic          sys_clk,
    // Access port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;   // Byte storage
        logic [DW-1:0]            rd;    // Read register
    } mem_state_t;

    mem_state_t st;
    mem_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Not reset: contents must survive every port resync
    always_comb
    begin
        next_st = st;
        if (int'(addr) < DEPTH)
        begin
            next_st.rd = st.mem[addr];
            if (we)
            begin
                next_st.mem[addr] = wdata;
            end
        end
        else
        begin
            next_st.rd = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st <= next_st;
    end

    assign rdata = st.rd;

endmodule // reg_bank_mem

// [verilog/dds_serial_control_port.sv]
`timescale 1ns/1ns

module dds_serial_control_port
    import dds_port_pkg::*;
#(
    parameter int UPDATE_PERIOD = 256
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Serial port pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        port_resync,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    output logic             serial_out_pin,
    output logic             serial_out_pin_oe,
    // Update strobe pin
    input  wire logic        register_transfer_strobe_in,
    output logic             register_transfer_strobe_out,
    output logic             register_transfer_strobe_oe,
    // Control word outputs
    output logic             comparator_pd,
    output logic             control_dac_pd,
    output logic             full_dac_pd,
    output logic             digital_pd,
    output logic             vco_high_gain,
    output logic             pll_bypass,
    output logic [4:0]       ref_mult,
    output logic             clear_acc1_pulse,
    output logic             clear_acc_hold,
    output logic             triangle_sweep,
    output op_mode_t         op_mode,
    output logic             inv_sinc_bypass,
    output logic             shaped_key_en,
    output logic             shaped_key_internal,
    output logic             halted
);

    typedef enum logic {ST_INSTR, ST_DATA} phase_t;

    typedef struct packed {
        logic [2:0]  sclk_sync;   // Pin synchronisers
        logic [2:0]  cs_sync;
        logic [2:0]  rs_sync;
        logic [2:0]  din_sync;
        logic [2:0]  stb_sync;
        logic        sclk_lvl;    // Filtered levels
        logic        cs_lvl;
        logic        rs_lvl;
        logic        stb_lvl;
        phase_t      phase;       // Instruction or data phase
        logic [2:0]  bit_cnt;     // Rising edges in current byte
        logic [2:0]  byte_cnt;    // Data bytes done
        logic [7:0]  instr;       // Latched instruction
        logic [7:0]  shreg;       // Incoming byte
        logic        out_bit;     // Outgoing data bit
        logic [31:0] ctrl_buf;    // Control word as written
        logic [31:0] ctrl;        // Control word in effect
        logic        clr_pulse;   // Accumulator clear pulse
        logic        halt;        // Sticky halt
        logic [15:0] upd_cnt;     // Internal update divider
        logic        upd_out;     // Internal update strobe
    } port_state_t;

    port_state_t st;
    port_state_t next_st;

    // Filtered level candidates and edges
    logic sclk_new;
    logic cs_new;
    logic rs_new;
    logic stb_new;
    logic rise;
    logic fall;
    logic update;
    logic lsb_first;
    logic [2:0] nbytes;
    logic [2:0] byte_off;
    logic [5:0] byte_addr;
    logic [1:0] lane;
    logic is_ctrl;
    logic [7:0] cur_byte;
    logic [7:0] mem_rdata;
    logic [7:0] assembled;
    logic mem_we;

    // A change counts once the second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        return (s[2] == s[1]) ? s[2] : lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address arithmetic for the current data byte
    always_comb
    begin
        lsb_first = st.ctrl[B_LSB_FIRST];
        nbytes = reg_bytes(st.instr[INSTR_ADDR_MSB:0]);
        // LSB-first walks the register from its low-order byte
        byte_off = lsb_first ? 3'(nbytes - 3'h1 - st.byte_cnt)
                             : st.byte_cnt;
        byte_addr = 6'(reg_base(st.instr[INSTR_ADDR_MSB:0]) + 6'(byte_off));
        is_ctrl = (st.instr[INSTR_ADDR_MSB:0] == CTRL_ADDR);
        lane = 2'(CTRL_TOP_LANE - 2'(byte_addr - CTRL_BASE));
        cur_byte = is_ctrl ? st.ctrl_buf[8*lane +: 8] : mem_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge finding on the synchronised pins
    always_comb
    begin
        sclk_new = filt(st.sclk_sync, st.sclk_lvl);
        cs_new = filt(st.cs_sync, st.cs_lvl);
        rs_new = filt(st.rs_sync, st.rs_lvl);
        stb_new = filt(st.stb_sync, st.stb_lvl);
        rise = sclk_new && !st.sclk_lvl;
        fall = !sclk_new && st.sclk_lvl;
        assembled = lsb_first ? {st.din_sync[2], st.shreg[7:1]}
                              : {st.shreg[6:0], st.din_sync[2]};
        // Internal or external update source, none once halted
        if (st.halt)
        begin
            update = 1'b0;
        end
        else if (st.ctrl[B_INT_UPD])
        begin
            update = st.upd_out;
        end
        else
        begin
            update = stb_new && !st.stb_lvl;
        end
        mem_we = !rs_new && !cs_new && rise && st.phase == ST_DATA
                 && st.bit_cnt == LAST_BIT && !st.instr[INSTR_READ_BIT]
                 && !is_ctrl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the whole port
    always_comb
    begin
        next_st = st;
        next_st.sclk_sync = {st.sclk_sync[1:0], sclk};
        next_st.cs_sync = {st.cs_sync[1:0], cs_n};
        next_st.rs_sync = {st.rs_sync[1:0], port_resync};
        next_st.din_sync = {st.din_sync[1:0], sdio_in};
        next_st.stb_sync = {st.stb_sync[1:0], register_transfer_strobe_in};
        next_st.sclk_lvl = sclk_new;
        next_st.cs_lvl = cs_new;
        next_st.rs_lvl = rs_new;
        next_st.stb_lvl = stb_new;
        next_st.clr_pulse = 1'b0;

        // Internal update generator
        next_st.upd_out = 1'b0;
        if (st.upd_cnt == 16'(UPDATE_PERIOD - 1))
        begin
            next_st.upd_cnt = '0;
            next_st.upd_out = 1'b1;
        end
        else
        begin
            next_st.upd_cnt = 16'(st.upd_cnt + 16'h0001);
        end

        // Transfer buffer to the live word; port setup changes here
        if (update)
        begin
            next_st.ctrl = st.ctrl_buf;
            if (st.ctrl_buf[B_CLR_ACC1])
            begin
                next_st.clr_pulse = 1'b1;
                next_st.ctrl_buf[B_CLR_ACC1] = 1'b0;
                next_st.ctrl[B_CLR_ACC1] = 1'b0;
            end
            if (st.ctrl_buf[B_HALT])
            begin
                next_st.halt = 1'b1;
            end
        end

        // Resync aborts, registers untouched
        if (rs_new)
        begin
            next_st.phase = ST_INSTR;
            next_st.bit_cnt = '0;
            next_st.byte_cnt = '0;
            next_st.out_bit = 1'b0;
        end
        // Edges while deselected are ignored, so the cycle resumes
        else if (!cs_new && rise)
        begin
            next_st.shreg = assembled;
            next_st.bit_cnt = 3'(st.bit_cnt + 3'h1);
            if (st.bit_cnt == LAST_BIT)
            begin
                if (st.phase == ST_INSTR)
                begin
                    next_st.instr = assembled;
                    next_st.phase = ST_DATA;
                    next_st.byte_cnt = '0;
                end
                else
                begin
                    // A write here lands after any update, so it wins
                    if (!st.instr[INSTR_READ_BIT] && is_ctrl)
                    begin
                        next_st.ctrl_buf[8*lane +: 8] = assembled;
                    end
                    next_st.byte_cnt = 3'(st.byte_cnt + 3'h1);
                    if (st.byte_cnt == 3'(nbytes - 3'h1))
                    begin
                        next_st.phase = ST_INSTR;
                    end
                end
            end
        end
        // Read data leaves on falling edges
        else if (!cs_new && fall && st.phase == ST_DATA
                 && st.instr[INSTR_READ_BIT])
        begin
            next_st.out_bit = lsb_first ? cur_byte[st.bit_cnt]
                                        : cur_byte[3'(LAST_BIT - st.bit_cnt)];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; master reset also clears the halt
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.sclk_lvl <= 1'b0;
            st.cs_lvl <= 1'b1;
            st.cs_sync <= 3'h7;
            st.phase <= ST_INSTR;
            st.ctrl_buf <= CTRL_RESET;
            st.ctrl <= CTRL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Non-control register bytes; never reset by resync
    reg_bank_mem #(
        .DW    (8),
        .AW    (6),
        .DEPTH (BANK_BYTES)
    ) u_bank (
        .sys_clk (sys_clk),
        .we      (mem_we),
        .addr    (byte_addr),
        .wdata   (assembled),
        .rdata   (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin drive: single-pin mode uses sdio, two-wire uses the out pin
    assign sdio_out = st.out_bit;
    assign serial_out_pin = st.out_bit;
    assign sdio_oe = !st.cs_lvl && !st.rs_lvl && st.phase == ST_DATA
                     && st.instr[INSTR_READ_BIT]
                     && !st.ctrl[B_OUT_ACTIVE];
    assign serial_out_pin_oe = !st.cs_lvl && st.ctrl[B_OUT_ACTIVE];
    assign register_transfer_strobe_out = st.upd_out;
    assign register_transfer_strobe_oe = st.ctrl[B_INT_UPD];

    // Control word fields to the rest of the device
    assign comparator_pd = st.ctrl[B_COMP_PD];
    assign control_dac_pd = st.ctrl[B_CDAC_PD];
    assign full_dac_pd = st.ctrl[B_DAC_PD];
    assign digital_pd = st.ctrl[B_DIG_PD];
    assign vco_high_gain = st.ctrl[B_VCO_GAIN];
    assign pll_bypass = st.ctrl[B_PLL_BYP];
    assign ref_mult = st.ctrl[B_MULT_MSB:B_MULT_LSB];
    assign clear_acc1_pulse = st.clr_pulse;
    assign clear_acc_hold = st.ctrl[B_CLR_ALL];
    assign triangle_sweep = st.ctrl[B_TRIANGLE];
    assign op_mode = op_mode_t'(st.ctrl[B_MODE_MSB:B_MODE_LSB]);
    assign inv_sinc_bypass = st.ctrl[B_SINC_BYP];
    assign shaped_key_en = st.ctrl[B_KEY_EN];
    assign shaped_key_internal = st.ctrl[B_KEY_INT];
    assign halted = st.halt;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_out_pin_idle: assert property (
        !st.ctrl[B_OUT_ACTIVE] |-> !serial_out_pin_oe)
        else $error("out pin driven in single-pin mode");

    chk_resync_abort: assert property (
        rs_new |=> st.phase == ST_INSTR && st.bit_cnt == 3'h0)
        else $error("resync did not abort transfer");

    chk_resync_keeps: assert property (
        rs_new && !update |=> st.ctrl_buf == $past(st.ctrl_buf))
        else $error("resync changed control buffer");

    chk_update_loads: assert property (
        update && !st.ctrl_buf[B_CLR_ACC1] |=> st.ctrl == $past(st.ctrl_buf))
        else $error("update did not load control word");

    chk_byte_count: assert property (
        !rs_new && !cs_new && rise && st.phase == ST_DATA
        && st.bit_cnt == LAST_BIT && st.byte_cnt == 3'(nbytes - 3'h1)
        |=> st.phase == ST_INSTR)
        else $error("data phase overran byte count");

    chk_clear_once: assert property (
        clear_acc1_pulse |=> !clear_acc1_pulse && !st.ctrl[B_CLR_ACC1])
        else $error("clear pulse not single");

    chk_halt_sticky: assert property (
        halted |=> halted && $stable(st.ctrl))
        else $error("halt released without reset");

    chk_cs_quiet: assert property (
        st.cs_lvl |-> !sdio_oe && !serial_out_pin_oe)
        else $error("pins driven while deselected");

    chk_instr_phase: assert property (
        st.phase == ST_INSTR && !rs_new && !cs_new && rise
        && st.bit_cnt == LAST_BIT |=> st.phase == ST_DATA)
        else $error("instruction not taken on eighth edge");

endmodule // dds_serial_control_port

// [tb/spi_host_model.sv]
`timescale 1ns/1ns

// Serial controller model: drives on sclk fall, samples on rise
module spi_host_model
(
    // Clock
    input  wire logic sys_clk,
    // Port pins
    output logic      sclk,
    output logic      cs_n,
    output logic      port_resync,
    output logic      mosi,
    input  wire logic miso
);
    logic        lsb_first; // Bit order the port expects
    logic [31:0] rx;        // Read bits, first arrival at the top

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        port_resync = 1'b0;
        mosi = 1'b0;
        lsb_first = 1'b0;
        rx = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One bit: 5 cycles low, 3 high, so 160 ns a bit
    task automatic bit_out(input logic b);
        sclk <= 1'b0;
        mosi <= b;
        repeat (5) @(posedge sys_clk);
        rx <= {rx[30:0], miso};
        sclk <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    // Whole bytes only, in the selected order
    task automatic byte_out(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            bit_out(lsb_first ? v[i] : v[7-i]);
    endtask

    // Select, leaving time for the pin synchronisers
    task automatic start();
        cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // Clock parks low; data line no longer holds its value
    task automatic stop();
        sclk <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (4) @(posedge sys_clk);
    endtask

    // Suspend mid-transfer; caller resumes with start
    task automatic pause();
        cs_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask

    // Resync pulse, lowered again before the next instruction
    task automatic resync();
        port_resync <= 1'b1;
        repeat (6) @(posedge sys_clk);
        port_resync <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // spi_host_model

// [tb/test_dds_serial_control_port.sv]
`timescale 1ns/1ns

`define CHECK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
        end \
    end

module test_dds_serial_control_port;
    import dds_port_pkg::*;

    localparam int CEIL = 20000; // Run limit in cycles
    localparam int UPD = 16;     // Internal update period in cycles
    logic       sys_clk, rst, sclk, cs_n, port_resync, mosi, miso;
    logic       sdio_in, sdio_out, sdio_oe, so_pin, so_oe;
    logic       strb_in, strb_out, strb_oe;
    logic       comp_pd, cdac_pd, fdac_pd, dig_pd, vco_hi, pll_byp;
    logic [4:0] ref_mult;
    logic       clr_pulse, clr_hold, tri_sw, sinc_byp, key_en, key_int;
    logic       halted;
    op_mode_t   op_mode;
    int         fails, total_checks, cycles, pulses, ticks;

    // Shared data pin resolved from both drivers
    assign sdio_in = sdio_oe ? sdio_out : mosi;
    assign miso = sdio_oe ? sdio_out : (so_oe ? so_pin : ~mosi);

    spi_host_model u_host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n),
        .port_resync(port_resync), .mosi(mosi), .miso(miso));

    // Short update period keeps the run brief
    dds_serial_control_port #(.UPDATE_PERIOD(UPD)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .port_resync(port_resync), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(so_pin),
        .serial_out_pin_oe(so_oe), .register_transfer_strobe_in(strb_in),
        .register_transfer_strobe_out(strb_out),
        .register_transfer_strobe_oe(strb_oe), .comparator_pd(comp_pd),
        .control_dac_pd(cdac_pd), .full_dac_pd(fdac_pd),
        .digital_pd(dig_pd), .vco_high_gain(vco_hi), .pll_bypass(pll_byp),
        .ref_mult(ref_mult), .clear_acc1_pulse(clr_pulse),
        .clear_acc_hold(clr_hold), .triangle_sweep(tri_sw),
        .op_mode(op_mode), .inv_sinc_bypass(sinc_byp),
        .shaped_key_en(key_en), .shaped_key_internal(key_int),
        .halted(halted));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle count, clear pulse count and hang limit
    always @(posedge sys_clk)
    begin
        cycles++;
        if (clr_pulse === 1'b1)
            pulses++;
        if (strb_out === 1'b1)
            ticks++;
        if (cycles == CEIL)
        begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Control word write, bytes ordered as the port expects
    task automatic wr_ctrl(input logic [31:0] w);
        u_host.start();
        u_host.byte_out(8'h07);
        for (int k = 0; k < 4; k++)
            u_host.byte_out(u_host.lsb_first ? w[8*k +: 8]
                                             : w[31-8*k -: 8]);
        u_host.stop();
    endtask

    // External update strobe, held long enough for the filter
    task automatic strobe();
        strb_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        strb_in <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    // Read back with a chip-select pause after the first data byte
    task automatic rd_ctrl(input logic [31:0] exp);
        logic [31:0] s;
        for (int i = 0; i < 32; i++)
            s[i] = u_host.lsb_first ? exp[31-i] : exp[i];
        u_host.start();
        u_host.byte_out(8'h87);
        u_host.byte_out(8'h00);
        `CHECK(({sdio_oe, so_oe}), exp[B_OUT_ACTIVE] ? 2'b01 : 2'b10)
        u_host.pause();
        `CHECK(({sdio_oe, so_oe}), 2'b00)
        u_host.start();
        repeat (3) u_host.byte_out(8'h00);
        u_host.stop();
        `CHECK(u_host.rx, s)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHECK(({comp_pd, vco_hi, pll_byp, ref_mult}), 8'hE4)
        `CHECK(({strb_oe, key_en, key_int, sinc_byp}), 4'hC)
        `CHECK(({so_oe, halted, tri_sw, clr_hold}), 4'h0)
        `CHECK(op_mode, MODE_SINGLE)
        // Internal strobe pulses, counted between falling edges
        @(negedge sys_clk);
        ticks = 0;
        repeat (2 * UPD) @(negedge sys_clk);
        `CHECK(ticks, 2)
        @(posedge sys_clk);
    endtask

    // Leave internal update mode, then check each field but the DAC, digital power-down, clear and halt ones
    task automatic t_ext();
        wr_ctrl(32'h0005_2450);
        strobe();
        `CHECK(({strb_oe, comp_pd, vco_hi, pll_byp, ref_mult}), 9'h005)
        `CHECK(({tri_sw, sinc_byp, key_en, key_int}), 4'hD)
        `CHECK(op_mode, MODE_RAMP_FSK)
        rd_ctrl(32'h0005_2450);
    endtask

    // Every mode, live only after the strobe
    task automatic t_modes();
        for (int m = 0; m < 5; m++)
        begin
            wr_ctrl(32'h0704_0000 | (32'(m) << 9));
            `CHECK(op_mode === op_mode_t'(m), 1'b0)
            strobe();
            `CHECK(op_mode, op_mode_t'(m))
            `CHECK(({cdac_pd, fdac_pd, dig_pd}), 3'h7)
        end
    endtask

    // One clear pulse, then the bit is gone
    task automatic t_clear();
        wr_ctrl(32'h0004_C000);
        pulses = 0;
        strobe();
        `CHECK(pulses, 1)
        `CHECK(clr_hold, 1'b1)
        `CHECK(({cdac_pd, fdac_pd, dig_pd}), 3'h0)
        pulses = 0;
        strobe();
        `CHECK(pulses, 0)
    endtask

    // A third byte to a two-byte register is an instruction
    task automatic t_surplus();
        logic [63:0] seq;
        seq = 64'h00AA_5577_0006_0800;
        u_host.start();
        for (int k = 0; k < 8; k++)
            u_host.byte_out(seq[63-8*k -: 8]);
        u_host.stop();
        strobe();
        `CHECK(({op_mode, ref_mult}), ({MODE_BPSK, 5'h06}))
    endtask

    // Resync in mid-byte keeps the word, next byte is an instruction
    task automatic t_resync();
        u_host.start();
        u_host.byte_out(8'h07);
        repeat (4) u_host.bit_out(1'b1);
        u_host.resync();
        rd_ctrl(32'h0006_0800);
        // Bank bytes written before the surplus edges are still there
        u_host.start();
        u_host.byte_out(8'h80);
        repeat (2) u_host.byte_out(8'h00);
        u_host.stop();
        `CHECK(u_host.rx[15:0], 16'hAA55)
    endtask

    // Bit order switch, instruction included, then a two-wire read
    task automatic t_lsb();
        wr_ctrl(32'h0006_0802);
        strobe();
        u_host.lsb_first = 1'b1;
        rd_ctrl(32'h0006_0802);
        wr_ctrl(32'h0006_0803);
        strobe();
        rd_ctrl(32'h0006_0803);
        wr_ctrl(32'h0006_0202);
        strobe();
        `CHECK(op_mode, MODE_FSK)
    endtask

    // Halt freezes the live word until master reset
    task automatic t_halt();
        wr_ctrl(32'h0800_0002);
        strobe();
        `CHECK(halted, 1'b1)
        wr_ctrl(32'h0004_0602);
        strobe();
        `CHECK(op_mode === MODE_CHIRP, 1'b0)
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        u_host.lsb_first = 1'b0;
        repeat (4) @(posedge sys_clk);
        `CHECK(({halted, ref_mult}), 6'h04)
    endtask

    initial
    begin
        rst = 1'b1;
        strb_in = 1'b0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        pulses = 0;
        ticks = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_ext();
        t_modes();
        t_clear();
        t_surplus();
        t_resync();
        t_lsb();
        t_halt();
        end_sim();
    end
endmodule // test_dds_serial_control_port
